// file: hw/rsa_alu.sv
`timescale 1ns/1ps
`default_nettype none
module rsa_alu
    import rsa_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire rsa_pkg::rsa_req_t    req,
    output var  logic [7:0]           acc,
    output var  rsa_pkg::rsa_flags_t  flags,
    output var  logic                 mem_we,
    output var  logic [7:0]           mem_wdata
);
    import rsa_pkg::*;

    // one-bit right rotate; the caller picks what fills bit 7
    function automatic logic [7:0] rot_right(
        input logic [7:0] v,
        input logic       fill
    );
        return {fill, v[RSA_MSB:1]};
    endfunction : rot_right

    wire rsa_op_t    op  = req.op;
    wire logic [7:0] m   = req.mem;

    wire logic is_rr  = (op == RSA_OP_RR_MEM)  || (op == RSA_OP_RR_ACC);
    wire logic is_rrc = (op == RSA_OP_RRC_MEM) || (op == RSA_OP_RRC_ACC);
    wire logic is_sbc = (op == RSA_OP_SBC_ACC) || (op == RSA_OP_SBC_MEM);
    wire logic to_mem = (op == RSA_OP_RR_MEM) || (op == RSA_OP_RRC_MEM)
                     || (op == RSA_OP_SBC_MEM);
    wire logic to_acc = (op == RSA_OP_RR_ACC) || (op == RSA_OP_RRC_ACC)
                     || (op == RSA_OP_SBC_ACC);

    wire logic [7:0] rot_plain = rot_right(m, m[0]);
    // same value feeds the accumulator form
    wire logic [7:0] rot_carry = rot_right(m, flags.c);

    wire logic       bin   = ~flags.c;
    wire logic [8:0] diff9 = {1'b0, acc} - {1'b0, m} - {8'h00, bin};
    wire logic [4:0] lo5   = {1'b0, acc[3:0]} - {1'b0, m[3:0]}
                           - {4'h0, bin};
    wire logic [7:0] diff  = diff9[RSA_MSB:0];
    wire logic       borrow = diff9[RSA_WIDTH];
    wire logic       ovf   = (acc[RSA_MSB] ^ m[RSA_MSB])
                           & (acc[RSA_MSB] ^ diff[RSA_MSB]);
    wire logic       zres  = (diff == 8'h00);

    wire logic [7:0] result = is_rr  ? rot_plain :
                              is_rrc ? rot_carry : diff;

    // flags carry over by default, so rotates touch only what they own
    rsa_flags_t next_flags;
    always_comb begin
        next_flags = flags;
        if (is_rrc) begin
            next_flags.c = m[0];
        end else if (is_sbc) begin
            next_flags.c  = ~borrow;
            next_flags.z  = zres;
            next_flags.ov = ovf;
            next_flags.ac = ~lo5[RSA_NIB];
            next_flags.sc = diff[RSA_MSB] ^ ovf;
            next_flags.cz = zres & flags.z;
        end
    end

    // mem_wdata keeps its last byte; only mem_we marks it as new,
    // so the write port need not be cleared between ops
    always_ff @(posedge clock) begin
        if (rst) begin
            acc       <= RSA_ACC_RESET;
            flags     <= RSA_FLAGS_RESET;
            mem_we    <= 1'b0;
            mem_wdata <= 8'h00;
        end else begin
            flags  <= next_flags;
            mem_we <= to_mem;
            if (to_mem) begin
                mem_wdata <= result;
            end
            if (to_acc) begin
                acc <= result;
            end
        end
    end

    // checks recompute from the sampled operands where they can,
    // so a wrong datapath wire cannot vouch for itself

    AST_RST_STATE: assert property (@(posedge clock)
        rst |=> acc == RSA_ACC_RESET && flags == RSA_FLAGS_RESET
            && !mem_we && mem_wdata == 8'h00)
        else $error("reset state wrong");

    AST_RR_MEM: assert property (@(posedge clock) disable iff (rst)
        op == RSA_OP_RR_MEM |=> mem_we && mem_wdata ==
            {$past(m[0]), $past(m[7:1])} && $stable(acc))
        else $error("rotate to memory wrong");

    AST_RR_ACC: assert property (@(posedge clock) disable iff (rst)
        op == RSA_OP_RR_ACC |=> !mem_we && $stable(flags)
            && acc == {$past(m[0]), $past(m[7:1])})
        else $error("rotate to accumulator wrong");

    AST_RRC_MEM: assert property (@(posedge clock) disable iff (rst)
        op == RSA_OP_RRC_MEM |=> mem_wdata ==
            {$past(flags.c), $past(m[7:1])} && flags.c == $past(m[0]))
        else $error("carry rotate to memory wrong");

    AST_RRC_ACC: assert property (@(posedge clock) disable iff (rst)
        op == RSA_OP_RRC_ACC |=> !mem_we && flags.c == $past(m[0])
            && acc == {$past(flags.c), $past(m[7:1])})
        else $error("carry rotate to accumulator wrong");

    AST_RRC_KEEP: assert property (@(posedge clock) disable iff (rst)
        op == RSA_OP_RRC_ACC |=> $stable(mem_wdata))
        else $error("carry rotate to accumulator touched memory");

    AST_ROT_FLAGS: assert property (@(posedge clock) disable iff (rst)
        (is_rr || is_rrc) |=> flags.z == $past(flags.z)
            && flags.ov == $past(flags.ov) && flags.ac == $past(flags.ac)
            && flags.sc == $past(flags.sc) && flags.cz == $past(flags.cz))
        else $error("rotate disturbed a flag");

    AST_RR_CARRY: assert property (@(posedge clock) disable iff (rst)
        is_rr |=> flags.c == $past(flags.c))
        else $error("plain rotate changed carry");

    AST_NONE_HOLD: assert property (@(posedge clock) disable iff (rst)
        op == RSA_OP_NONE |=> !mem_we && $stable(acc) && $stable(flags)
            && $stable(mem_wdata))
        else $error("idle cycle changed state");

    AST_RRC_MEM_WE: assert property (@(posedge clock) disable iff (rst)
        op == RSA_OP_RRC_MEM |=> mem_we && $stable(acc))
        else $error("carry rotate to memory missed the write");

    AST_ACC_NO_WE: assert property (@(posedge clock) disable iff (rst)
        to_acc |=> !mem_we && $stable(mem_wdata))
        else $error("accumulator op wrote memory");

    AST_WE_SOURCE: assert property (@(posedge clock) disable iff (rst)
        mem_we |-> $past(to_mem))
        else $error("memory write without a memory op");

    AST_SBC_ACC: assert property (@(posedge clock) disable iff (rst)
        op == RSA_OP_SBC_ACC |=> !mem_we && acc == 8'($past(acc)
            - $past(m) - {7'h00, ~$past(flags.c)}))
        else $error("subtract to accumulator wrong");

    AST_SBC_MEM: assert property (@(posedge clock) disable iff (rst)
        op == RSA_OP_SBC_MEM |=> mem_we && $stable(acc)
            && mem_wdata == 8'($past(acc) - $past(m)
            - {7'h00, ~$past(flags.c)}))
        else $error("subtract to memory wrong");

    AST_SBC_CARRY: assert property (@(posedge clock) disable iff (rst)
        is_sbc |=> flags.c == ({1'b0, $past(acc)} >=
            ({1'b0, $past(m)} + {8'h00, ~$past(flags.c)})))
        else $error("subtract carry wrong");

    AST_SBC_ZERO: assert property (@(posedge clock) disable iff (rst)
        is_sbc |=> flags.z == (8'($past(acc) - $past(m)
            - {7'h00, ~$past(flags.c)}) == 8'h00))
        else $error("subtract zero flag wrong");

    AST_SBC_OV: assert property (@(posedge clock) disable iff (rst)
        is_sbc |=> flags.ov == (($past(acc[7]) ^ $past(m[7]))
            && ($past(acc[7])
            ^ ($past(to_mem) ? mem_wdata[7] : acc[7]))))
        else $error("subtract overflow flag wrong");

    AST_SBC_AC: assert property (@(posedge clock) disable iff (rst)
        is_sbc |=> flags.ac == ({1'b0, $past(acc[3:0])}
            >= ({1'b0, $past(m[3:0])} + {4'h0, ~$past(flags.c)})))
        else $error("subtract half borrow flag wrong");

    AST_SBC_CZ: assert property (@(posedge clock) disable iff (rst)
        is_sbc |=> flags.cz == (flags.z && $past(flags.z)))
        else $error("chained zero flag wrong");

    AST_SBC_SC: assert property (@(posedge clock) disable iff (rst)
        is_sbc |=> flags.sc == (flags.ov ^ $past(diff[7])))
        else $error("signed borrow flag wrong");

    // signed borrow is the sign of the true, unclipped signed difference
    AST_SBC_SIGN: assert property (@(posedge clock) disable iff (rst)
        is_sbc |=> flags.sc == ($signed({$past(acc[7]), $past(acc)})
            < ($signed({$past(m[7]), $past(m)})
            + $signed({8'h00, ~$past(flags.c)}))))
        else $error("signed borrow against compare wrong");

endmodule : rsa_alu
`default_nettype wire

// file: hw/rsa_pkg.sv
package rsa_pkg;

    // operation select from the decoder
    typedef enum logic [2:0] {
        RSA_OP_NONE,
        RSA_OP_RR_MEM,
        RSA_OP_RR_ACC,
        RSA_OP_RRC_MEM,
        RSA_OP_RRC_ACC,
        RSA_OP_SBC_ACC,
        RSA_OP_SBC_MEM
    } rsa_op_t;

    localparam int RSA_WIDTH = 8;
    localparam int RSA_MSB   = 7;
    localparam int RSA_NIB   = 4;
    localparam logic [7:0] RSA_ACC_RESET = 8'h00;

    // status flags as one carrier
    typedef struct packed {
        logic ov;   // signed_excess_flag
        logic z;
        logic ac;   // half_borrow_flag
        logic c;
        logic sc;   // signed_borrow_flag
        logic cz;   // chained_zero_flag
    } rsa_flags_t;

    localparam rsa_flags_t RSA_FLAGS_RESET = '0;

    // request from the decoder: operation plus fetched operand
    typedef struct packed {
        rsa_op_t    op;
        logic [7:0] mem;
    } rsa_req_t;

endpackage : rsa_pkg

// file: tb/rsa_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// decoder and data memory stand-in; operand fetch is combinational
module rsa_mem_model
    import rsa_pkg::*;
(
    input  wire logic              clock,
    input  wire rsa_pkg::rsa_op_t  op,
    input  wire logic [1:0]        addr,
    input  wire logic              mem_we,
    input  wire logic [7:0]        mem_wdata,
    output var  rsa_pkg::rsa_req_t req
);
    logic [7:0] mem [4] = '{8'h81, 8'h00, 8'h7f, 8'hc3};
    logic [1:0] addr_q = 2'h0;
    assign req = '{op: op, mem: mem[addr]};
    // write lands one edge late, so ops must not hit the same byte back to back
    always @(posedge clock) begin
        addr_q <= addr;
        if (mem_we) begin
            mem[addr_q] <= mem_wdata;
        end
    end
endmodule : rsa_mem_model
`default_nettype wire

// file: tb/rotate_subtract_alu_ops_test.sv
`timescale 1ns/1ps
`default_nettype none
module rotate_subtract_alu_ops_test;
    import rsa_pkg::*;
    logic       clock = 1'b0;
    logic       rst   = 1'b1;
    rsa_op_t    op    = RSA_OP_NONE;
    logic [1:0] addr  = 2'h0;
    rsa_req_t   req;
    rsa_flags_t flags;
    logic [7:0] acc;
    logic [7:0] mem_wdata;
    logic       mem_we;
    logic [7:0] em [4] = '{8'h81, 8'h00, 8'h7f, 8'hc3};
    logic [7:0] ea = 8'h00;
    rsa_flags_t ef = '0;
    int         error_cnt = 0;
    int         cmp_count = 0;
    rsa_op_t    sq [14] = '{RSA_OP_RRC_ACC, RSA_OP_RR_MEM, RSA_OP_RRC_MEM,
        RSA_OP_RR_ACC, RSA_OP_SBC_ACC, RSA_OP_SBC_MEM, RSA_OP_SBC_ACC,
        RSA_OP_SBC_ACC, RSA_OP_RR_MEM, RSA_OP_SBC_ACC, RSA_OP_SBC_ACC,
        RSA_OP_SBC_MEM, RSA_OP_RRC_ACC, RSA_OP_RRC_MEM};
    logic [1:0] sa [14] = '{2'h0, 2'h0, 2'h3, 2'h2, 2'h2, 2'h3, 2'h3,
        2'h2, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2};
    initial begin
        forever #20 clock = ~clock;
    end
    rsa_mem_model rsa_mem_model_i (.clock(clock), .op(op), .addr(addr),
        .mem_we(mem_we), .mem_wdata(mem_wdata), .req(req));
    rsa_alu rsa_alu_i (.clock(clock), .rst(rst), .req(req), .acc(acc),
        .flags(flags), .mem_we(mem_we), .mem_wdata(mem_wdata));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic do_op(input rsa_op_t o, input logic [1:0] a);
        logic [7:0] m;
        logic [8:0] d;
        logic [4:0] l;
        logic       w;
        m = em[a];
        w = o inside {RSA_OP_RR_MEM, RSA_OP_RRC_MEM, RSA_OP_SBC_MEM};
        d = {1'b0, ea} - {1'b0, m} - 9'(!ef.c);
        l = {1'b0, ea[3:0]} - {1'b0, m[3:0]} - 5'(!ef.c);
        if (o inside {RSA_OP_RR_MEM, RSA_OP_RR_ACC}) begin
            d = {1'b0, m[0], m[7:1]};
        end else if (o inside {RSA_OP_RRC_MEM, RSA_OP_RRC_ACC}) begin
            d = {1'b0, ef.c, m[7:1]};
            ef.c = m[0];
        end else begin
            ef.ov = (ea[7] ^ m[7]) & (ea[7] ^ d[7]);
            ef.cz = (d[7:0] == 8'h00) & ef.z;
            ef.z = (d[7:0] == 8'h00);
            ef.ac = !l[4];
            ef.c = !d[8];
            ef.sc = d[7] ^ ef.ov;
        end
        if (w) em[a] = d[7:0];
        else ea = d[7:0];
        @(posedge clock);
        op <= o;
        addr <= a;
        @(posedge clock);
        op <= RSA_OP_NONE;
        #1;
        chk(acc, ea);
        chk({2'h0, flags}, {2'h0, ef});
        chk({7'h0, mem_we}, {7'h0, w});
        if (w) chk(mem_wdata, d[7:0]);
    endtask : do_op
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        #1;
        chk(acc, 8'h00);
        chk({2'h0, flags}, 8'h00);
        chk({7'h0, mem_we}, 8'h00);
        // every op, overflow, borrow and chained zero cases
        for (int i = 0; i < 14; i++) begin
            do_op(sq[i], sa[i]);
        end
        summarize();
    end
endmodule : rotate_subtract_alu_ops_test
`default_nettype wire
